// [atrc_core.sv]
// Purpose: Trigger, result and compare control of a successive-approximation converter
// Assumes: Engine answers each start with one i_conv_done pulse carrying a 10-bit result
// Notes:   Register port: one-cycle strobes, read data one cycle later
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "atrc_params.svh"

// Notes on behaviour
// - Active flag sets when a conversion starts, clears on completion or abort.
// - Trigger select picks software write or hardware input as start source.
// - Compare bit one enables compare function, zero disables it.
// - Direction zero means result below value; one means greater or equal.
// - High result holds top two bits; reads zero in 8-bit mode.
// - Results load on completion unless compare is on and false.
// - In 10-bit mode, high read blocks transfers until low read; drops results.
// - In 8-bit mode no interlock; results transfer regardless of read order.
// - Changing width mode invalidates both result registers until a new store.
// - Low result holds low eight bits, or the whole 8-bit result.
// - Compare-high bits used in 10-bit mode only, ignored in 8-bit mode.
// - Compare-low bits checked against low eight result bits in both modes.
// - Complete flag sets per completion gated by compare; cleared by writes/low reads.
// - Complete flag rising with interrupt enable high sets the done status; o_irq also needs its mask bit.
// - Width mode 00 selects 8-bit, 10 selects 10-bit; 01 and 11 reserved.
// - Writing control one aborts conversion, restarts in software trigger mode unless channel is all ones.
module atrc_core
    import atrc_pkg::*;
#(
    parameter int CONV_CYCLES = (`ATRC_CONV_NS + `ATRC_CLK_NS - 1) / `ATRC_CLK_NS
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_hw_trigger,
    input  wire logic       i_conv_done,
    input  wire logic [9:0] i_conv_data,
    output logic            o_conv_start,
    output logic            o_conv_abort,
    output logic      [4:0] o_channel,
    output logic            o_mode_10bit,
    output logic            o_irq
);
    // Elaboration-time refusal of a conversion length the logic cannot serve
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_cycles_check
        $error("CONV_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // Hardware trigger synchroniser
    // ------------------------------------------------------------
    logic hwt_level;
    logic hwt_rise;

    atrc_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (i_hw_trigger),
        .o_level    (hwt_level),
        .o_rise     (hwt_rise)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    atrc_state_type  state_ff;
    atrc_state_type  nxt_state;
    logic [7:0]      sc1_ff;
    logic [7:0]      nxt_sc1;
    logic [5:4]      sc2_cmp_ff;
    logic [5:4]      nxt_sc2_cmp;
    logic            trig_ff;
    logic            nxt_trig;
    logic [1:0]      mode_ff;
    logic [1:0]      nxt_mode;
    logic [7:0]      cfg_ff;
    logic [7:0]      nxt_cfg;
    logic [1:0]      cmp_hi_ff;
    logic [1:0]      nxt_cmp_hi;
    logic [7:0]      cmp_lo_ff;
    logic [7:0]      nxt_cmp_lo;
    atrc_result_type res_ff;
    atrc_result_type nxt_res;
    logic            lock_ff;
    logic            nxt_lock;
    logic [1:0]      stat_ff;
    logic [1:0]      nxt_stat;
    logic [1:0]      mask_ff;
    logic [1:0]      nxt_mask;
    logic [7:0]      rdata_ff;
    logic [7:0]      nxt_rdata;

    logic wr_sc1;
    logic rd_lo;
    logic rd_hi;
    logic start;
    logic cmp_true;
    logic store;
    logic drop;
    logic mode10;

    // Compare with width taken from the mode: returns condition
    function automatic logic cmp_eval(input logic [9:0] res, input logic [1:0] hi,
                                      input logic [7:0] lo, input logic wide, input logic ge);
        logic [9:0] val;
        logic [9:0] r;
        val = wide ? {hi, lo} : {2'h0, lo};
        r   = wide ? res : {2'h0, res[7:0]};
        return ge ? (r >= val) : (r < val);
    endfunction

    assign mode10 = (mode_ff == `ATRC_MODE_10BIT);
    assign wr_sc1 = i_wr && (i_addr == `ATRC_OFS_SC1);
    assign rd_lo  = i_rd && (i_addr == `ATRC_OFS_RES_LO);
    assign rd_hi  = i_rd && (i_addr == `ATRC_OFS_RES_HI);

    // Software start on control-one write, hardware start on trigger edge
    // Hardware start looks at the stored channel, never at idle write data
    assign start = (wr_sc1 && !trig_ff && i_wdata[4:0] != `ATRC_CHAN_OFF)
                 || (trig_ff && hwt_rise && !wr_sc1
                     && sc1_ff[4:0] != `ATRC_CHAN_OFF);

    assign cmp_true = cmp_eval(i_conv_data, cmp_hi_ff, cmp_lo_ff, mode10, sc2_cmp_ff[4]);
    assign store    = i_conv_done && (state_ff == ATRC_BUSY) && !wr_sc1
                    && (!sc2_cmp_ff[5] || cmp_true);
    assign drop     = store && mode10 && lock_ff;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_sc1     = sc1_ff;
        nxt_sc2_cmp = sc2_cmp_ff;
        nxt_trig    = trig_ff;
        nxt_mode    = mode_ff;
        nxt_cfg     = cfg_ff;
        nxt_cmp_hi  = cmp_hi_ff;
        nxt_cmp_lo  = cmp_lo_ff;
        nxt_res     = res_ff;
        nxt_lock    = lock_ff;
        nxt_stat    = stat_ff;
        nxt_mask    = mask_ff;
        nxt_rdata   = 8'h00;

        unique case (state_ff)
            ATRC_IDLE: begin
                if (start && trig_ff && !wr_sc1) begin
                    nxt_state = ATRC_BUSY;
                end
            end
            ATRC_BUSY: begin
                if (i_conv_done) begin
                    nxt_state = ATRC_IDLE;
                end
            end
        endcase
        if (wr_sc1) begin
            nxt_state = start ? ATRC_BUSY : ATRC_IDLE;
        end

        if (store && !drop) begin
            nxt_res.valid = 1'b1;
            nxt_res.data  = mode10 ? i_conv_data : {2'h0, i_conv_data[7:0]};
        end
        if (store) begin
            nxt_sc1[`ATRC_SC1_DONE] = 1'b1;
        end
        if (rd_hi && mode10) begin
            nxt_lock = 1'b1;
        end
        if (rd_lo || !mode10) begin
            nxt_lock = 1'b0;
        end
        if (rd_lo && !store) begin
            nxt_sc1[`ATRC_SC1_DONE] = 1'b0;
        end

        // Sticky interrupt status, set wins over clear
        if (i_wr && i_addr == `ATRC_OFS_IRQ_STAT) begin
            nxt_stat = stat_ff & ~i_wdata[1:0];
        end
        if (store && !sc1_ff[`ATRC_SC1_DONE] && sc1_ff[`ATRC_SC1_IEN]) begin
            nxt_stat[`ATRC_IRQ_DONE] = 1'b1;
        end
        if (drop) begin
            nxt_stat[`ATRC_IRQ_DISCARD] = 1'b1;
        end

        if (i_wr) begin
            unique case (i_addr)
                `ATRC_OFS_SC1: begin
                    nxt_sc1 = {1'b0, i_wdata[6:0]};
                end
                `ATRC_OFS_SC2: begin
                    nxt_trig    = i_wdata[`ATRC_SC2_TRIG];
                    nxt_sc2_cmp = i_wdata[5:4];
                end
                `ATRC_OFS_CMP_HI: nxt_cmp_hi = i_wdata[1:0];
                `ATRC_OFS_CMP_LO: nxt_cmp_lo = i_wdata;
                `ATRC_OFS_CFG: begin
                    nxt_cfg  = i_wdata;
                    nxt_mode = i_wdata[`ATRC_CFG_MODE_LO +: 2];
                    if (nxt_mode != mode_ff) begin
                        nxt_res.valid = 1'b0;
                        nxt_lock      = 1'b0;
                    end
                end
                `ATRC_OFS_IRQ_MASK: nxt_mask = i_wdata[1:0];
                default: ;
            endcase
        end

        if (i_rd) begin
            unique case (i_addr)
                `ATRC_OFS_SC1:      nxt_rdata = sc1_ff;
                `ATRC_OFS_SC2:      nxt_rdata = {state_ff == ATRC_BUSY, trig_ff, sc2_cmp_ff, 4'h0};
                `ATRC_OFS_RES_HI:   nxt_rdata = (mode10 && res_ff.valid) ? {6'h00, res_ff.data[9:8]} : 8'h00;
                `ATRC_OFS_RES_LO:   nxt_rdata = res_ff.valid ? res_ff.data[7:0] : 8'h00;
                `ATRC_OFS_CMP_HI:   nxt_rdata = {6'h00, cmp_hi_ff};
                `ATRC_OFS_CMP_LO:   nxt_rdata = cmp_lo_ff;
                `ATRC_OFS_CFG:      nxt_rdata = cfg_ff;
                `ATRC_OFS_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
                `ATRC_OFS_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_ff   <= ATRC_IDLE;
            sc1_ff     <= `ATRC_SC1_RESET;
            sc2_cmp_ff <= 2'h0;
            trig_ff    <= 1'b0;
            mode_ff    <= `ATRC_MODE_8BIT;
            cfg_ff     <= 8'h00;
            cmp_hi_ff  <= 2'h0;
            cmp_lo_ff  <= 8'h00;
            res_ff     <= '0;
            lock_ff    <= 1'b0;
            stat_ff    <= 2'h0;
            mask_ff    <= 2'h0;
            rdata_ff   <= 8'h00;
        end else begin
            state_ff   <= nxt_state;
            sc1_ff     <= nxt_sc1;
            sc2_cmp_ff <= nxt_sc2_cmp;
            trig_ff    <= nxt_trig;
            mode_ff    <= nxt_mode;
            cfg_ff     <= nxt_cfg;
            cmp_hi_ff  <= nxt_cmp_hi;
            cmp_lo_ff  <= nxt_cmp_lo;
            res_ff     <= nxt_res;
            lock_ff    <= nxt_lock;
            stat_ff    <= nxt_stat;
            mask_ff    <= nxt_mask;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign o_rdata      = rdata_ff;
    assign o_conv_start = (start && (wr_sc1 || state_ff == ATRC_IDLE));
    assign o_conv_abort = wr_sc1 && (state_ff == ATRC_BUSY);
    assign o_channel    = sc1_ff[4:0];
    assign o_mode_10bit = mode10;
    assign o_irq        = |(stat_ff & mask_ff);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_locked;
        lock_ff && mode10;
    endsequence
    sequence s_done_no_lo;
        !rd_lo && !wr_sc1 && store && mode10 && !(i_wr && i_addr == `ATRC_OFS_CFG);
    endsequence

    AST_ACTIVE_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_conv_start |=> state_ff == ATRC_BUSY) else $error("active flag not set on start");
    AST_ACTIVE_CLR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_ff == ATRC_BUSY && i_conv_done && !start) |=> state_ff == ATRC_IDLE)
        else $error("active flag not cleared");
    AST_HW_ONLY: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (hwt_rise && !trig_ff && !wr_sc1) |-> !o_conv_start) else $error("hw start in sw mode");
    AST_SW_START: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_sc1 && !trig_ff && i_wdata[4:0] != `ATRC_CHAN_OFF) |-> o_conv_start)
        else $error("sw write did not start");
    AST_CMP_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_conv_done && sc2_cmp_ff[5] && !cmp_true) |=> $stable(res_ff.data))
        else $error("result stored on false compare");
    AST_LOCK: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_locked ##0 s_done_no_lo |=> $stable(res_ff.data)) else $error("interlock broken");
    AST_HI_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (rd_hi && !mode10) |=> o_rdata == 8'h00) else $error("high result not zero");
    AST_DONE_FLAG: assert property (@(posedge i_core_clk) disable iff (i_rst)
        store |=> sc1_ff[`ATRC_SC1_DONE]) else $error("complete flag not set");
    AST_MODE_INVAL: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wr && i_addr == `ATRC_OFS_CFG && i_wdata[3:2] != mode_ff) |=> !res_ff.valid)
        else $error("result valid after mode change");
endmodule

// [atrc_engine_model.sv]
// Purpose: Conversion engine stand-in facing the converter control block
// Assumes: One start pulse begins a conversion lasting DLY cycles
// Notes:   Result lines toggle every cycle outside the completion cycle
`timescale 1ns/1ns
module atrc_engine_model #(
    parameter int DLY = 8
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic       i_abort,
    input  wire logic       i_mode_10bit,
    input  wire logic [9:0] i_value,
    output logic            o_done,
    output logic      [9:0] o_data
);
    int         cnt_ff;
    logic [9:0] val_ff;

    assign o_done = (cnt_ff == 1);

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_ff <= 0;
            o_data <= 10'h155;
        end else begin
            o_data <= (cnt_ff == 2) ? val_ff : ~o_data;
            if (i_start) begin
                cnt_ff <= DLY;
                val_ff <= i_mode_10bit ? i_value : {2'b00, i_value[7:0]};
            end else if (i_abort) begin
                cnt_ff <= 0;
            end else if (cnt_ff != 0) begin
                cnt_ff <= cnt_ff - 1;
            end
        end
    end
endmodule

// [atrc_params.svh]
// Purpose: Offsets, field positions, reset values and timing in nanoseconds of the converter control block
// Assumes: Byte-wide registers on a plain strobe port, one address per register
// Notes:   Definitions only
`ifndef ATRC_PARAMS_SVH
`define ATRC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ATRC_OFS_SC1       4'h0
`define ATRC_OFS_SC2       4'h1
`define ATRC_OFS_RES_HI    4'h2
`define ATRC_OFS_RES_LO    4'h3
`define ATRC_OFS_CMP_HI    4'h4
`define ATRC_OFS_CMP_LO    4'h5
`define ATRC_OFS_CFG       4'h6
`define ATRC_OFS_IRQ_STAT  4'h7
`define ATRC_OFS_IRQ_MASK  4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATRC_SC2_ACTIVE    7
`define ATRC_SC2_TRIG      6
`define ATRC_SC2_CMP_EN    5
`define ATRC_SC2_CMP_GE    4
`define ATRC_SC1_DONE      7
`define ATRC_SC1_IEN       6
`define ATRC_CFG_MODE_LO   2
`define ATRC_IRQ_DONE      0
`define ATRC_IRQ_DISCARD   1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ATRC_SC1_RESET     8'h1F
`define ATRC_CHAN_OFF      5'h1F
`define ATRC_MODE_8BIT     2'h0
`define ATRC_MODE_10BIT    2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ATRC_CONV_NS       400
`define ATRC_CLK_NS        4

`endif

// [atrc_pkg.sv]
// Purpose: Types shared by the converter control block
// Assumes: Nothing
// Notes:   Constants live in atrc_params.svh
package atrc_pkg;

    typedef enum logic [1:0] {
        ATRC_IDLE,
        ATRC_BUSY
    } atrc_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } atrc_bus_type;

    typedef struct packed {
        logic       valid;
        logic [9:0] data;
    } atrc_result_type;

endpackage

// [atrc_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter and rising-edge pulse
// Assumes: Input asynchronous to i_core_clk
// Notes:   First stage is read only by the second
`timescale 1ns/1ns
module atrc_sync (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_rise
);
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic       level_ff;
    logic       nxt_level;

    always_comb begin
        nxt_sync  = {sync_ff[1:0], i_async};
        nxt_level = level_ff;
        if (sync_ff[2] == sync_ff[1]) begin
            nxt_level = sync_ff[2];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync_ff  <= 3'h0;
            level_ff <= 1'b0;
        end else begin
            sync_ff  <= nxt_sync;
            level_ff <= nxt_level;
        end
    end

    assign o_level = level_ff;
    assign o_rise  = nxt_level & ~level_ff;
endmodule

// [test_adc_trigger_result_compare.sv]
// Purpose: Self-checking bench of the converter control block
// Assumes: Engine stand-in answers each start after a fixed delay
// Notes:   Reads note their expected data in a queue checked by a monitor
`timescale 1ns/1ns
`include "atrc_params.svh"
module test_adc_trigger_result_compare;
    localparam logic [3:0] SC1 = `ATRC_OFS_SC1, SC2 = `ATRC_OFS_SC2, HI = `ATRC_OFS_RES_HI, LO = `ATRC_OFS_RES_LO;
    localparam logic [3:0] CVH = `ATRC_OFS_CMP_HI, CVL = `ATRC_OFS_CMP_LO, CFG = `ATRC_OFS_CFG;
    localparam logic [3:0] STAT = `ATRC_OFS_IRQ_STAT, MASK = `ATRC_OFS_IRQ_MASK;
    logic       i_core_clk, i_rst, i_wr, i_rd, i_hw_trigger, rd_ff, eng_done, m10, ge, hit;
    logic       o_conv_start, o_conv_abort, o_mode_10bit, o_irq;
    logic [3:0] i_addr;
    logic [4:0] chan;
    logic [7:0] i_wdata, o_rdata;
    logic [9:0] eng_value, eng_data, last, d, cv, cve;
    logic [9:0] exp_q[$];
    int         miscompares = 0, tests_run = 0, starts = 0, aborts = 0, s0, a0;
    integer     seed = 32'hba5a_ff14;

    atrc_core dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_hw_trigger(i_hw_trigger), .i_conv_done(eng_done),
        .i_conv_data(eng_data), .o_conv_start(o_conv_start), .o_conv_abort(o_conv_abort),
        .o_channel(chan), .o_mode_10bit(o_mode_10bit), .o_irq(o_irq));
    atrc_engine_model eng_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_start(o_conv_start),
        .i_abort(o_conv_abort), .i_mode_10bit(o_mode_10bit), .i_value(eng_value), .o_done(eng_done),
        .o_data(eng_data));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        exp_q.push_back({2'b00, e});
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 64 && eng_done !== 1'b1; i++) begin
            @(posedge i_core_clk);
            #1;
        end
        chk("done", {9'd0, eng_done}, 10'd1);
    endtask
    task automatic conv(input logic [9:0] v, input logic [7:0] ctl);
        eng_value <= v;
        wr(SC1, ctl);
        wait_done();
    endtask
    task automatic res(input logic [9:0] e);
        rd(HI, {6'd0, m10 ? e[9:8] : 2'b00});
        rd(LO, e[7:0]);
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("irq", {9'd0, o_irq}, {9'd0, v});
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Monitor and watchdog
    // ----------------------------------------------------------------
    always @(posedge i_core_clk) begin
        rd_ff <= i_rd;
        if (o_conv_start === 1'b1) starts <= starts + 1;
        if (o_conv_abort === 1'b1) aborts <= aborts + 1;
        if (rd_ff === 1'b1) chk("rdata", {2'b00, o_rdata}, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        miscompares++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        i_rst <= 1'b1;
        {i_wr, i_rd, i_addr, i_wdata, i_hw_trigger} <= 15'h0000;
        m10 = 1'b0;
        eng_value <= 10'h000;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(SC1, 8'h1F);
        rd(SC2, 8'h00);
        res(10'h000);
        rd(4'h9, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(CVL, 8'hA5);
        rd(CVL, 8'hA5);
        wr(SC2, 8'h30);
        rd(SC2, 8'h30);
        wr(SC2, 8'h00);
        d = 10'($random(seed)) & 10'h0FF | 10'h001;
        eng_value <= d;
        wr(SC1, 8'h05);
        rd(SC2, 8'h80);
        wait_done();
        rd(SC2, 8'h00);
        rd(SC1, 8'h85);
        res(d);
        rd(SC1, 8'h05);
        m10 = 1'b1;
        wr(CFG, 8'h08);
        res(10'h000);
        d = 10'($random(seed));
        conv(d, 8'h05);
        res(d);
        rd(HI, {6'd0, d[9:8]});
        conv(~d, 8'h05);
        res(d);
        rd(STAT, 8'h02);
        wr(STAT, 8'h02);
        conv(~d, 8'h05);
        res(~d);
        m10 = 1'b0;
        wr(CFG, 8'h00);
        d = 10'($random(seed)) & 10'h0FF;
        rd(HI, 8'h00);
        conv(d, 8'h05);
        rd(LO, d[7:0]);
        wr(CFG, 8'h08);
        for (int k = 0; k < 16; k++) begin
            m10  = k[0];
            ge   = k[1];
            last = 10'h000;
            wr(CFG, m10 ? 8'h08 : 8'h00);
            wr(SC2, {2'b00, 1'b1, ge, 4'h0});
            cv = 10'($random(seed));
            d  = (k < 8) ? cv - {9'd0, k[2]} : 10'($random(seed));
            wr(CVH, {6'd0, cv[9:8]});
            wr(CVL, cv[7:0]);
            d    = m10 ? d : {2'b00, d[7:0]};
            cve  = m10 ? cv : {2'b00, cv[7:0]};
            hit  = ge ? (d >= cve) : (d < cve);
            last = hit ? d : last;
            conv(d, 8'h05);
            chk("mode", {9'd0, o_mode_10bit}, {9'd0, m10});
            chk("channel", {5'd0, chan}, 10'h005);
            rd(SC1, {hit, 7'h05});
            res(last);
        end
        wr(SC2, 8'h00);
        s0 = starts;
        a0 = aborts;
        eng_value <= 10'h0AB;
        wr(SC1, 8'h05);
        wr(SC1, 8'h1F);
        rd(SC2, 8'h00);
        repeat (16) @(posedge i_core_clk);
        res(last);
        chk("starts", 10'(starts - s0), 10'd1);
        chk("abort", {9'd0, aborts > a0}, 10'd1);
        s0 = starts;
        d  = 10'($random(seed));
        eng_value <= d;
        wr(SC1, 8'h05);
        wr(SC1, 8'h05);
        wait_done();
        res(d);
        wr(SC2, 8'h40);
        wr(SC1, 8'h05);
        chk("starts", 10'(starts - s0), 10'd2);
        d = 10'($random(seed));
        eng_value <= d;
        i_hw_trigger <= 1'b1;
        wait_done();
        @(posedge i_core_clk);
        i_hw_trigger <= 1'b0;
        res(d);
        chk("starts", 10'(starts - s0), 10'd3);
        wr(SC2, 8'h00);
        i_hw_trigger <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        i_hw_trigger <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        chk("starts", 10'(starts - s0), 10'd3);
        wr(MASK, 8'h03);
        conv(d, 8'h45);
        irq_is(1'b1);
        rd(STAT, 8'h01);
        wr(STAT, 8'h01);
        irq_is(1'b0);
        wr(MASK, 8'h00);
        conv(d, 8'h45);
        irq_is(1'b0);
        rd(STAT, 8'h01);
        repeat (3) @(posedge i_core_clk);
        end_of_test();
    end
endmodule
